// [rtl/crc16_engine_config_pkg.sv]
package crc16_engine_config_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CHECK_CONFIG = 8'hc1;
    localparam logic [7:0]  ADDR_RESULT_LOW   = 8'hc2;
    localparam logic [7:0]  ADDR_RESULT_HIGH  = 8'hc3;

    // ------------------------------------------------------------
    // configuration fields and reset values
    // ------------------------------------------------------------
    localparam int          CFG_CHECK_EN_BIT  = 0;
    localparam int          CFG_MODEM_BIT     = 1;
    localparam int          CFG_RANGE_LSB     = 4;
    localparam int          CFG_RANGE_MSB     = 7;
    localparam logic [7:0]  CFG_RESET         = 8'h00;
    localparam logic [15:0] RESULT_RESET      = 16'h0000;
    localparam logic [7:0]  RDATA_UNMAPPED    = 8'h00;

    // ------------------------------------------------------------
    // crc and span constants
    // ------------------------------------------------------------
    localparam logic [15:0] CRC_POLY_REFL     = 16'ha001;
    localparam int          BLOCK_SHIFT       = 12;
    localparam logic [16:0] FULL_SPAN         = 17'h10000;
    localparam logic [16:0] REF_BYTES         = 17'h00002;

    typedef enum logic [1:0] {
        CHK_IDLE = 2'b00,
        CHK_RUN  = 2'b01,
        CHK_CMP  = 2'b10
    } check_state_t;

    // fold one byte, lsb first, into a reflected crc-16
    function automatic logic [15:0] crc_fold_byte(input logic [15:0] crc_in, input logic [7:0] data);
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
        end
        return c;
    endfunction : crc_fold_byte
endpackage : crc16_engine_config_pkg

// [rtl/crc16_engine_config.sv]
`timescale 1ns/10ps
module crc16_engine_config (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_sfr_rd,
    output logic      [7:0]  o_sfr_rdata,
    input  wire logic        i_loader_cfg_wr,
    input  wire logic [7:0]  i_loader_cfg_data,
    input  wire logic        i_check_request,
    output logic             o_mem_rd_valid,
    input  wire logic        i_mem_rd_ready,
    output logic      [15:0] o_mem_rd_addr,
    input  wire logic        i_mem_data_valid,
    output logic             o_mem_data_ready,
    input  wire logic [7:0]  i_mem_data,
    output logic             o_check_busy,
    output logic             o_app_start,
    output logic             o_load_mode,
    output logic             o_modem_fallback
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]                             crc_reg;
    logic [7:0]                              cfg_reg;
    logic [7:0]                              rdata_reg;
    crc16_engine_config_pkg::check_state_t   state_reg;
    logic [16:0]                             req_cnt_reg;
    logic [16:0]                             rcv_cnt_reg;
    logic [16:0]                             span;
    logic [15:0]                             ref_reg;
    logic                                    start_reg;
    logic                                    load_reg;
    logic                                    modem_reg;
    logic [7:0]                              buf_data_reg [2];
    logic [1:0]                              buf_cnt_reg;
    logic                                    buf_rd_ptr_reg;
    logic                                    buf_wr_ptr_reg;
    logic                                    buf_push;
    logic                                    buf_pop;
    logic                                    buf_out_valid;
    logic                                    sw_write;
    logic                                    is_ref_byte;

    // ------------------------------------------------------------
    // check span
    // ------------------------------------------------------------
    // span in bytes; nibble zero taken as the full 64kB
    always_comb begin
        if (cfg_reg[crc16_engine_config_pkg::CFG_RANGE_MSB:crc16_engine_config_pkg::CFG_RANGE_LSB] == 4'h0) begin
            span = crc16_engine_config_pkg::FULL_SPAN;
        end else begin
            span = 17'({13'h0000, cfg_reg[crc16_engine_config_pkg::CFG_RANGE_MSB:
                       crc16_engine_config_pkg::CFG_RANGE_LSB]} << crc16_engine_config_pkg::BLOCK_SHIFT);
        end
    end

    // ------------------------------------------------------------
    // two-entry buffer on the memory data path
    // ------------------------------------------------------------
    assign sw_write         = i_sfr_wr && (i_sfr_addr == crc16_engine_config_pkg::ADDR_RESULT_LOW);
    assign o_mem_data_ready = (buf_cnt_reg != 2'd2);
    assign buf_push         = i_mem_data_valid && o_mem_data_ready;
    assign buf_out_valid    = (buf_cnt_reg != 2'd0);
    // software write owns the engine this cycle, drain stalls
    assign buf_pop          = buf_out_valid && !sw_write && (state_reg == crc16_engine_config_pkg::CHK_RUN);
    assign is_ref_byte      = (rcv_cnt_reg >= (span - crc16_engine_config_pkg::REF_BYTES));

    // buffer storage and pointers
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            buf_cnt_reg    <= 2'd0;
            buf_rd_ptr_reg <= 1'b0;
            buf_wr_ptr_reg <= 1'b0;
        end else begin
            if (buf_push) begin
                buf_data_reg[buf_wr_ptr_reg] <= i_mem_data;
                buf_wr_ptr_reg               <= ~buf_wr_ptr_reg;
            end
            if (buf_pop) begin
                buf_rd_ptr_reg <= ~buf_rd_ptr_reg;
            end
            buf_cnt_reg <= 2'(buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop});
        end
    end

    // ------------------------------------------------------------
    // crc engine
    // ------------------------------------------------------------
    // software write folds byte; check drain folds range bytes except the two reference bytes at its end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            crc_reg <= crc16_engine_config_pkg::RESULT_RESET;
        end else if (sw_write) begin
            crc_reg <= crc16_engine_config_pkg::crc_fold_byte(crc_reg, i_sfr_wdata);
        end else if (state_reg == crc16_engine_config_pkg::CHK_IDLE && i_check_request
                     && cfg_reg[crc16_engine_config_pkg::CFG_CHECK_EN_BIT]) begin
            crc_reg <= crc16_engine_config_pkg::RESULT_RESET;
        end else if (buf_pop && !is_ref_byte) begin
            crc_reg <= crc16_engine_config_pkg::crc_fold_byte(crc_reg, buf_data_reg[buf_rd_ptr_reg]);
        end
    end

    // ------------------------------------------------------------
    // configuration register, loader-written only
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cfg_reg <= crc16_engine_config_pkg::CFG_RESET;
        end else if (i_loader_cfg_wr) begin
            cfg_reg <= i_loader_cfg_data;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // data registered, valid the cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_reg <= crc16_engine_config_pkg::RDATA_UNMAPPED;
        end else if (i_sfr_rd) begin
            case (i_sfr_addr)
                crc16_engine_config_pkg::ADDR_CHECK_CONFIG: rdata_reg <= cfg_reg;
                crc16_engine_config_pkg::ADDR_RESULT_LOW:   rdata_reg <= crc_reg[7:0];
                crc16_engine_config_pkg::ADDR_RESULT_HIGH:  rdata_reg <= crc_reg[15:8];
                default:                                    rdata_reg <= crc16_engine_config_pkg::RDATA_UNMAPPED;
            endcase
        end
    end
    assign o_sfr_rdata = rdata_reg;

    // ------------------------------------------------------------
    // power-up / watchdog check sequencer
    // ------------------------------------------------------------
    // request addresses zero to span-1 in order
    assign o_mem_rd_valid = (state_reg == crc16_engine_config_pkg::CHK_RUN) && (req_cnt_reg < span);
    assign o_mem_rd_addr  = req_cnt_reg[15:0];
    assign o_check_busy   = (state_reg != crc16_engine_config_pkg::CHK_IDLE);

    // request, receive and compare
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_reg   <= crc16_engine_config_pkg::CHK_IDLE;
            req_cnt_reg <= 17'h00000;
            rcv_cnt_reg <= 17'h00000;
            ref_reg     <= 16'h0000;
            start_reg   <= 1'b0;
            load_reg    <= 1'b0;
            modem_reg   <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                crc16_engine_config_pkg::CHK_IDLE: begin
                    if (i_check_request) begin
                        req_cnt_reg <= 17'h00000;
                        rcv_cnt_reg <= 17'h00000;
                        // a new request drops the previous outcome
                        load_reg    <= 1'b0;
                        modem_reg   <= 1'b0;
                        if (cfg_reg[crc16_engine_config_pkg::CFG_CHECK_EN_BIT]) begin
                            state_reg <= crc16_engine_config_pkg::CHK_RUN;
                        end else begin
                            start_reg <= 1'b1;
                        end
                    end
                end
                crc16_engine_config_pkg::CHK_RUN: begin
                    // count accepted requests
                    if (o_mem_rd_valid && i_mem_rd_ready) begin
                        req_cnt_reg <= 17'(req_cnt_reg + 17'h00001);
                    end
                    // count drained bytes
                    if (buf_pop) begin
                        rcv_cnt_reg <= 17'(rcv_cnt_reg + 17'h00001);
                        // low byte first, then high byte
                        if (is_ref_byte) begin
                            ref_reg <= {buf_data_reg[buf_rd_ptr_reg], ref_reg[15:8]};
                        end
                        if (rcv_cnt_reg == 17'(span - 17'h00001)) begin
                            state_reg <= crc16_engine_config_pkg::CHK_CMP;
                        end
                    end
                end
                crc16_engine_config_pkg::CHK_CMP: begin
                    state_reg <= crc16_engine_config_pkg::CHK_IDLE;
                    // folded bytes against stored reference
                    if (crc_reg != ref_reg) begin
                        load_reg  <= 1'b1;
                        modem_reg <= cfg_reg[crc16_engine_config_pkg::CFG_MODEM_BIT];
                    end else begin
                        start_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= crc16_engine_config_pkg::CHK_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // check outcome
    // ------------------------------------------------------------
    assign o_app_start      = start_reg;
    assign o_load_mode      = load_reg;
    assign o_modem_fallback = modem_reg;
endmodule : crc16_engine_config

// [testbench/crc16_engine_config_monitor.sv]
`timescale 1ns/10ps
module crc16_engine_config_monitor (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic [7:0]  i_sfr_addr,
    input wire logic        i_sfr_rd,
    input wire logic [7:0]  o_sfr_rdata,
    input wire logic        i_loader_cfg_wr,
    input wire logic [7:0]  i_loader_cfg_data,
    input wire logic        i_check_request,
    input wire logic        o_mem_rd_valid,
    input wire logic [15:0] o_mem_rd_addr,
    input wire logic        o_check_busy,
    input wire logic        o_app_start,
    input wire logic        o_load_mode,
    input wire logic        o_modem_fallback
);
    logic [7:0]  cfg_reg;
    logic [16:0] span;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // shadow of the loader-written configuration
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) cfg_reg <= 8'h00;
        else if (i_loader_cfg_wr) cfg_reg <= i_loader_cfg_data;
    end
    assign span = (cfg_reg[7:4] == 4'h0) ? 17'h10000 : {1'b0, cfg_reg[7:4], 12'h000};
    sequence req_idle_s;
        i_check_request && !o_check_busy && !i_loader_cfg_wr;
    endsequence
    reset_zero_a: assert property (disable iff (1'b0) !i_reset_n |=> o_sfr_rdata == 8'h00 && !o_load_mode)
        else $error("result not zero after reset");
    cfg_read_a: assert property (i_sfr_rd && i_sfr_addr == 8'hc1 && !i_loader_cfg_wr |=> o_sfr_rdata == cfg_reg)
        else $error("config readback wrong");
    skip_start_a: assert property (req_idle_s ##0 !cfg_reg[0] |-> ##[1:2] o_app_start)
        else $error("no start with check off");
    check_busy_a: assert property (req_idle_s ##0 cfg_reg[0] |=> o_check_busy)
        else $error("check did not start");
    span_addr_a: assert property (o_mem_rd_valid |-> {1'b0, o_mem_rd_addr} < span)
        else $error("read outside span");
    first_addr_a: assert property ($rose(o_check_busy) |-> o_mem_rd_addr == 16'h0000)
        else $error("span not from zero");
    one_outcome_a: assert property ($fell(o_check_busy) |-> o_app_start != o_load_mode)
        else $error("check outcome wrong");
    modem_flag_a: assert property ($rose(o_load_mode) |-> o_modem_fallback == cfg_reg[1])
        else $error("modem fallback wrong");
    load_nostart_a: assert property (o_load_mode |-> !o_app_start)
        else $error("start while in load mode");
endmodule : crc16_engine_config_monitor

// [testbench/mem_model.sv]
`timescale 1ns/10ps
module mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_rd_valid,
    output logic             o_rd_ready,
    input  wire logic [15:0] i_rd_addr,
    output logic             o_data_valid,
    input  wire logic        i_data_ready,
    output logic      [7:0]  o_data,
    input  wire logic [15:0] i_bad_addr
);
    logic [15:0] pend_q[$];
    logic [15:0] a;
    // memory of zeros but one byte; stalls every other cycle, answers in order
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            pend_q.delete();
            o_rd_ready <= 1'b0;
            o_data_valid <= 1'b0;
            o_data <= 8'h5a;
        end else begin
            o_rd_ready <= ~o_rd_ready;
            if (i_rd_valid && o_rd_ready) pend_q.push_back(i_rd_addr);
            if (!o_data_valid || i_data_ready) begin
                if (pend_q.size() > 0) begin
                    a = pend_q.pop_front();
                    o_data_valid <= 1'b1;
                    o_data <= (a == i_bad_addr) ? 8'h01 : 8'h00;
                end else begin
                    o_data_valid <= 1'b0;
                    o_data <= ~o_data; // released bus shows no stale byte
                end
            end
        end
    end
endmodule : mem_model

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
    logic        i_clk = 1'b0, i_reset_n = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    logic        i_loader_cfg_wr = 1'b0, i_check_request = 1'b0, o_mem_rd_valid, i_mem_rd_ready;
    logic        i_mem_data_valid, o_mem_data_ready, o_check_busy, o_app_start, o_load_mode, o_modem_fallback;
    logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_loader_cfg_data = 8'h00, o_sfr_rdata, i_mem_data;
    logic [15:0] o_mem_rd_addr, bad_addr = 16'h0000;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    always #2 i_clk = ~i_clk;
    crc16_engine_config u_crc16_engine_config (.i_clk, .i_reset_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd,
        .o_sfr_rdata, .i_loader_cfg_wr, .i_loader_cfg_data, .i_check_request, .o_mem_rd_valid, .i_mem_rd_ready,
        .o_mem_rd_addr, .i_mem_data_valid, .o_mem_data_ready, .i_mem_data, .o_check_busy, .o_app_start,
        .o_load_mode, .o_modem_fallback);
    mem_model u_mem_model (.i_clk, .i_reset_n, .i_rd_valid(o_mem_rd_valid), .o_rd_ready(i_mem_rd_ready),
        .i_rd_addr(o_mem_rd_addr), .o_data_valid(i_mem_data_valid), .i_data_ready(o_mem_data_ready),
        .o_data(i_mem_data), .i_bad_addr(bad_addr));
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) {i_sfr_wr, i_sfr_addr, i_sfr_wdata} <= {1'b1, a, d};
        @(posedge i_clk) i_sfr_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk) {i_sfr_rd, i_sfr_addr} <= {1'b1, a};
        @(posedge i_clk) i_sfr_rd <= 1'b0;
        #1 d = o_sfr_rdata;
    endtask : rd
    task automatic result(input logic [15:0] exp);
        logic [7:0] h, l;
        rd(8'hc3, h);
        rd(8'hc2, l);
        cmp({h, l}, exp);
    endtask : result
    // single fold, then nine back-to-back folds, then the two-write clear
    task automatic test_fold();
        logic [7:0] b[9] = '{8'h8a, 8'h0b, 8'h75, 8'hc7, 8'haa, 8'h75, 8'hc7, 8'h55, 8'h43};
        result(16'h0000);
        wr(8'hc2, 8'h75);
        result(16'he7c1);
        foreach (b[i]) @(posedge i_clk) {i_sfr_wr, i_sfr_addr, i_sfr_wdata} <= {1'b1, 8'hc2, b[i]};
        @(posedge i_clk) i_sfr_wr <= 1'b0;
        result(16'hd6b5);
        wr(8'hc2, 8'hb5);
        result(16'h00d6);
        wr(8'hc2, 8'hd6);
        result(16'h0000);
    endtask : test_fold
    // loader config, refused software writes, unmapped read
    task automatic test_cfg();
        logic [7:0] d;
        @(posedge i_clk) {i_loader_cfg_wr, i_loader_cfg_data} <= {1'b1, 8'hd2};
        @(posedge i_clk) i_loader_cfg_wr <= 1'b0;
        wr(8'hc1, 8'h0f);
        wr(8'hc3, 8'hff);
        rd(8'hc1, d);
        cmp({8'h00, d}, 16'h00d2);
        result(16'h0000);
        rd(8'h00, d);
        cmp({8'h00, d}, 16'h0000);
    endtask : test_cfg
    // one power-up check over the configured span with one odd byte
    task automatic run_check(input logic [7:0] cfg, input logic [15:0] bad, input logic [2:0] exp);
        int n;
        @(posedge i_clk) {i_loader_cfg_wr, i_loader_cfg_data, bad_addr} <= {1'b1, cfg, bad};
        @(posedge i_clk) {i_loader_cfg_wr, i_check_request} <= 2'b01;
        @(posedge i_clk) i_check_request <= 1'b0;
        #1 n = 0;
        while (!(o_app_start === 1'b1 || o_load_mode === 1'b1) && n < 40000) begin
            @(posedge i_clk) n++;
            #1;
        end
        cmp({13'h0000, o_app_start, o_load_mode, o_modem_fallback}, {13'h0000, exp});
        repeat (3) @(posedge i_clk);
    endtask : run_check
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        test_fold();
        test_cfg();
        run_check(8'h00, 16'h0000, 3'b100);
        run_check(8'h11, 16'h1000, 3'b100);
        run_check(8'h11, 16'h0ffe, 3'b010);
        run_check(8'h21, 16'h1000, 3'b010);
        run_check(8'h13, 16'h0fff, 3'b011);
        run_check(8'h00, 16'h0000, 3'b100);
        end_sim();
    end
    // cycle ceiling against hangs
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            error_cnt++;
            end_sim();
        end
    end
endmodule : tb
bind crc16_engine_config crc16_engine_config_monitor u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_sfr_addr(i_sfr_addr), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .i_loader_cfg_wr(i_loader_cfg_wr),
    .i_loader_cfg_data(i_loader_cfg_data), .i_check_request(i_check_request), .o_mem_rd_valid(o_mem_rd_valid),
    .o_mem_rd_addr(o_mem_rd_addr), .o_check_busy(o_check_busy), .o_app_start(o_app_start),
    .o_load_mode(o_load_mode), .o_modem_fallback(o_modem_fallback));
